// *** common/aks_pkg.sv ***
// Constants, types and helpers shared by both converter kernel ends
package aks_pkg;
   // ----------------------------------------
   // Register map, word index within a kernel
   // ----------------------------------------
   localparam logic [7:0] OFS_SYNC_CTRL = 8'h1a;
   localparam logic [7:0] OFS_EMUX_EN = 8'hd6;
   localparam logic [7:0] OFS_GLOBAL_CTRL = 8'h00;
   localparam logic [7:0] OFS_CONV_REQ = 8'h02;
   localparam logic [7:0] OFS_GLOBAL_STAT = 8'h04;
   localparam logic [15:0] KERNEL0_BASE = 16'he000;
   localparam logic [15:0] KERNEL1_BASE = 16'he100;
   localparam int ADDR_W = 18;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 16;
   localparam int OFS_W = 8;

   // ----------------------------------------
   // Field layouts and reset values
   // ----------------------------------------
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] SYNC_WMASK = 16'h0013;
   localparam logic [15:0] EMUX_WMASK = 16'h5555;
   localparam logic [15:0] GCTRL_WMASK = 16'h0003;
   localparam int START_SELECTION_LSB = 0;
   localparam int EVAL_BIT = 4;
   localparam int ACT_LSB = 0;
   localparam int REQ_CHAN_LSB = 0;
   localparam int REQ_SYNC_BIT = 4;
   localparam int REQ_GO_BIT = 5;
   localparam int ST_ACT_LSB = 0;
   localparam int ST_STATE_LSB = 2;
   localparam int ST_CHAN_LSB = 4;
   localparam int ST_BUSY_BIT = 8;
   localparam int ST_PAR_BIT = 9;
   localparam int ST_PEND_BIT = 10;
   localparam int CHAN_W = 4;
   localparam int EMUX_CHANS = 8;
   localparam int NUM_SRQ = 4;
   localparam int SRQ_DONE = 0;
   localparam int SRQ_PAR_DONE = 1;
   localparam int SRQ_BAD_SEL = 2;
   localparam int SRQ_CFG_LIVE = 3;

   // ----------------------------------------
   // Codes and timing
   // ----------------------------------------
   localparam logic [1:0] ROLE_MASTER = 2'h0;
   localparam logic [1:0] ROLE_SLAVE = 2'h1;
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_ON = 2'h3;
   localparam int CNT_W = 8;
   localparam int SAMPLE_CYC = 4;
   localparam int CONV_CYC = 12;

   typedef enum logic [1:0] {
      AKS_IDLE = 2'h0,
      AKS_WAIT = 2'h1,
      AKS_SAMPLE = 2'h3,
      AKS_CONVERT = 2'h2
   } aks_state_t;

   function automatic logic aks_active(input logic [1:0] code);
      aks_active = (code != ACT_OFF);
   endfunction : aks_active

   function automatic logic [15:0] aks_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0] be,
                                             input logic [15:0] wmask);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}};
      aks_merge = ((old_v & ~lanes) | (new_v & lanes)) & wmask;
   endfunction : aks_merge
endpackage : aks_pkg

// *** common/aks_link_if.sv ***
// Link between two converter kernels of one conversion group
`timescale 1ns/10ps
interface aks_link_if;
   import aks_pkg::*;
   // Driven by the register-programmed kernel
   logic [1:0] dev_act;
   logic dev_sync_req;
   logic [CHAN_W-1:0] dev_chan;
   logic dev_ready;
   // Driven by the peer kernel
   logic [1:0] peer_act;
   logic peer_sync_req;
   logic [CHAN_W-1:0] peer_chan;
   logic peer_ready;

   modport dev_end (
      output dev_act, dev_sync_req, dev_chan, dev_ready,
      input peer_act, peer_sync_req, peer_chan, peer_ready
   );
   modport peer_end (
      input dev_act, dev_sync_req, dev_chan, dev_ready,
      output peer_act, peer_sync_req, peer_chan, peer_ready
   );
endinterface : aks_link_if

// *** rtl/aks_kernel.sv ***
// Converter kernel with sync control, mux enable and Avalon-MM registers
`timescale 1ns/10ps
module aks_kernel #(
   parameter logic [15:0] BASE = aks_pkg::KERNEL0_BASE,
   parameter int SAMPLE_CYC = aks_pkg::SAMPLE_CYC,
   parameter int CONV_CYC = aks_pkg::CONV_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Link to peer kernel
   aks_link_if.dev_end link,
   // Avalon-MM slave
   input wire logic [aks_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Kernel outputs
   output logic [aks_pkg::NUM_SRQ-1:0] service_request,
   output logic ext_mux_active,
   output logic converting
);
   import aks_pkg::*;

   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [15:0] sync_q;
   logic [15:0] emux_q;
   logic [15:0] gctrl_q;
   logic pend_q;
   logic pend_sync_q;
   logic [CHAN_W-1:0] pend_chan_q;
   logic wait_q;
   logic [31:0] rdata_q;
   aks_state_t state_q;
   aks_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CHAN_W-1:0] chan_q;
   logic [CHAN_W-1:0] chan_d;
   logic par_q;
   logic par_d;
   logic [NUM_SRQ-1:0] srq_d;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire [IDX_W-1:0] idx = avs_address[IDX_LSB +: IDX_W];
   wire hit = (idx[IDX_W-1:OFS_W] == BASE[IDX_W-1:OFS_W]);
   wire [OFS_W-1:0] ofs = idx[OFS_W-1:0];
   wire req = avs_read | avs_write;
   wire wr_en = avs_write & ~wait_q & hit;
   wire wr_sync = wr_en & (ofs == OFS_SYNC_CTRL);
   wire wr_emux = wr_en & (ofs == OFS_EMUX_EN);
   wire wr_gctrl = wr_en & (ofs == OFS_GLOBAL_CTRL);
   wire wr_conv = wr_en & (ofs == OFS_CONV_REQ) & avs_byteenable[0];
   wire [15:0] wdata = avs_writedata[15:0];
   wire [1:0] be = avs_byteenable[1:0];
   wire [15:0] sync_new = aks_merge(sync_q, wdata, be, SYNC_WMASK);
   wire [15:0] emux_new = aks_merge(emux_q, wdata, be, EMUX_WMASK);

   // ----------------------------------------
   // Role and activity selection
   // ----------------------------------------
   wire [1:0] start_selection = sync_q[START_SELECTION_LSB +: 2];
   wire is_master = (start_selection == ROLE_MASTER);
   wire is_slave = (start_selection == ROLE_SLAVE);
   wire eval_ready = sync_q[EVAL_BIT];
   wire [1:0] own_act = gctrl_q[ACT_LSB +: 2];
   wire [1:0] eff_act = is_master ? own_act
                      : is_slave ? link.peer_act
                      : ACT_OFF;
   wire active = aks_active(eff_act);
   wire take_master = is_slave & link.peer_sync_req;
   wire own_par = pend_sync_q & is_master & eval_ready;
   wire peer_ok = link.peer_ready | ~par_q;
   wire last_cnt = (cnt_q == '0);
   wire [CNT_W-1:0] sample_load = CNT_W'(SAMPLE_CYC - 1);
   wire [CNT_W-1:0] conv_load = CNT_W'(CONV_CYC - 1);
   wire run_d = (state_d == AKS_SAMPLE) | (state_d == AKS_CONVERT);
   wire emux_hit = (chan_d < CHAN_W'(EMUX_CHANS)) & emux_q[{chan_d[2:0], 1'b0}];
   wire taken = (state_q == AKS_IDLE) & active & ~take_master & pend_q;

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      chan_d = chan_q;
      par_d = par_q;
      srq_d = '0;
      case (state_q)
         AKS_IDLE:
         begin
            if (active && take_master)
            begin
               chan_d = link.peer_chan;
               par_d = eval_ready;
               state_d = eval_ready ? AKS_WAIT : AKS_SAMPLE;
               cnt_d = sample_load;
            end
            else if (taken)
            begin
               chan_d = pend_chan_q;
               par_d = own_par;
               state_d = own_par ? AKS_WAIT : AKS_SAMPLE;
               cnt_d = sample_load;
            end
         end
         AKS_WAIT:
         begin
            if (peer_ok)
            begin
               state_d = AKS_SAMPLE;
            end
         end
         AKS_SAMPLE:
         begin
            cnt_d = cnt_q - CNT_W'(1);
            if (last_cnt)
            begin
               state_d = AKS_CONVERT;
               cnt_d = conv_load;
            end
         end
         AKS_CONVERT:
         begin
            cnt_d = cnt_q - CNT_W'(1);
            if (last_cnt)
            begin
               state_d = AKS_IDLE;
               srq_d[SRQ_DONE] = 1'b1;
               srq_d[SRQ_PAR_DONE] = par_q;
               par_d = 1'b0;
            end
         end
         default:
         begin
            state_d = AKS_IDLE;
         end
      endcase
      srq_d[SRQ_BAD_SEL] = wr_sync & sync_new[START_SELECTION_LSB + 1];
      srq_d[SRQ_CFG_LIVE] = wr_sync & (aks_active(own_act) | aks_active(link.peer_act));
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= AKS_IDLE;
         cnt_q <= '0;
         chan_q <= '0;
         par_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         chan_q <= chan_d;
         par_q <= par_d;
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_q <= REG_RESET;
         emux_q <= REG_RESET;
         gctrl_q <= REG_RESET;
         pend_q <= 1'b0;
         pend_sync_q <= 1'b0;
         pend_chan_q <= '0;
      end
      else
      begin
         if (wr_sync)
            sync_q <= sync_new;
         if (wr_emux)
            emux_q <= emux_new;
         if (wr_gctrl)
            gctrl_q <= aks_merge(gctrl_q, wdata, be, GCTRL_WMASK);
         if (wr_conv && wdata[REQ_GO_BIT])
         begin
            pend_q <= 1'b1;
            pend_sync_q <= wdata[REQ_SYNC_BIT];
            pend_chan_q <= wdata[REQ_CHAN_LSB +: CHAN_W];
         end
         else if (taken)
            pend_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read path and handshake
   // ----------------------------------------
   wire [15:0] stat_word = {5'h00, pend_q, par_q, ~(state_q == AKS_IDLE),
                            chan_q, state_q, eff_act};
   wire [15:0] rd_mux = ~hit ? 16'h0000
                      : (ofs == OFS_SYNC_CTRL) ? sync_q
                      : (ofs == OFS_EMUX_EN) ? emux_q
                      : (ofs == OFS_GLOBAL_CTRL) ? gctrl_q
                      : (ofs == OFS_CONV_REQ) ? {11'h000, pend_sync_q, pend_chan_q}
                      : (ofs == OFS_GLOBAL_STAT) ? stat_word
                      : 16'h0000;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_q <= 1'b1;
         rdata_q <= '0;
      end
      else
      begin
         wait_q <= ~(req & wait_q);
         if (req && wait_q)
            rdata_q <= {16'h0000, rd_mux};
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.dev_act <= ACT_OFF;
         link.dev_sync_req <= 1'b0;
         link.dev_chan <= '0;
         link.dev_ready <= 1'b0;
         service_request <= '0;
         ext_mux_active <= 1'b0;
         converting <= 1'b0;
      end
      else
      begin
         link.dev_act <= eff_act;
         link.dev_sync_req <= is_master & par_d & (state_d == AKS_WAIT);
         link.dev_chan <= chan_d;
         link.dev_ready <= (state_d == AKS_WAIT);
         service_request <= srq_d;
         ext_mux_active <= run_d & emux_hit;
         converting <= run_d;
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;
endmodule : aks_kernel

// *** rtl/aks_peer.sv ***
// Peer converter kernel driven from plain user-side control ports
`timescale 1ns/10ps
module aks_peer #(
   parameter int SAMPLE_CYC = aks_pkg::SAMPLE_CYC,
   parameter int CONV_CYC = aks_pkg::CONV_CYC
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Link to the other kernel
   aks_link_if.peer_end link,
   // Configuration
   input wire logic [1:0] cfg_start_selection,
   input wire logic cfg_peer_ready_evaluate,
   input wire logic [1:0] cfg_activity_control_code,
   // Conversion requests
   input wire logic req_valid,
   input wire logic req_sync,
   input wire logic [aks_pkg::CHAN_W-1:0] req_chan,
   output logic req_ack,
   output logic conv_done,
   output logic busy
);
   import aks_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [1:0] sel_q;
   logic eval_q;
   logic [1:0] act_q;
   aks_state_t state_q;
   aks_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CHAN_W-1:0] chan_d;
   logic [CHAN_W-1:0] chan_q;
   logic par_q;
   logic par_d;
   logic ack_d;
   logic done_d;

   wire both_off = ~aks_active(act_q) & ~aks_active(link.dev_act);
   wire is_master = (sel_q == ROLE_MASTER);
   wire is_slave = (sel_q == ROLE_SLAVE);
   wire [1:0] eff_act = is_master ? act_q : is_slave ? link.dev_act : ACT_OFF;
   wire active = aks_active(eff_act);
   wire take_master = is_slave & link.dev_sync_req;
   wire own_par = req_sync & is_master & eval_q;
   wire last_cnt = (cnt_q == '0);
   wire [CNT_W-1:0] sample_load = CNT_W'(SAMPLE_CYC - 1);
   wire [CNT_W-1:0] conv_load = CNT_W'(CONV_CYC - 1);

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      chan_d = chan_q;
      par_d = par_q;
      ack_d = 1'b0;
      done_d = 1'b0;
      case (state_q)
         AKS_IDLE:
         begin
            if (active && take_master)
            begin
               chan_d = link.dev_chan;
               par_d = eval_q;
               state_d = eval_q ? AKS_WAIT : AKS_SAMPLE;
               cnt_d = sample_load;
            end
            else if (active && req_valid)
            begin
               ack_d = 1'b1;
               chan_d = req_chan;
               par_d = own_par;
               state_d = own_par ? AKS_WAIT : AKS_SAMPLE;
               cnt_d = sample_load;
            end
         end
         AKS_WAIT:
         begin
            if (link.dev_ready || !par_q)
               state_d = AKS_SAMPLE;
         end
         AKS_SAMPLE:
         begin
            cnt_d = cnt_q - CNT_W'(1);
            if (last_cnt)
            begin
               state_d = AKS_CONVERT;
               cnt_d = conv_load;
            end
         end
         AKS_CONVERT:
         begin
            cnt_d = cnt_q - CNT_W'(1);
            if (last_cnt)
            begin
               state_d = AKS_IDLE;
               done_d = 1'b1;
               par_d = 1'b0;
            end
         end
         default:
         begin
            state_d = AKS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_q <= ROLE_MASTER;
         eval_q <= 1'b0;
         act_q <= ACT_OFF;
         state_q <= AKS_IDLE;
         cnt_q <= '0;
         chan_q <= '0;
         par_q <= 1'b0;
      end
      else
      begin
         if (both_off)
         begin
            sel_q <= cfg_start_selection;
            eval_q <= cfg_peer_ready_evaluate;
         end
         act_q <= cfg_activity_control_code;
         state_q <= state_d;
         cnt_q <= cnt_d;
         chan_q <= chan_d;
         par_q <= par_d;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         link.peer_act <= ACT_OFF;
         link.peer_sync_req <= 1'b0;
         link.peer_chan <= '0;
         link.peer_ready <= 1'b0;
         req_ack <= 1'b0;
         conv_done <= 1'b0;
         busy <= 1'b0;
      end
      else
      begin
         link.peer_act <= eff_act;
         link.peer_sync_req <= is_master & par_d & (state_d == AKS_WAIT);
         link.peer_chan <= chan_d;
         link.peer_ready <= (state_d == AKS_WAIT);
         req_ack <= ack_d;
         conv_done <= done_d;
         busy <= (state_d != AKS_IDLE);
      end
   end
endmodule : aks_peer

// *** sim/aks_link_properties.sv ***
// Concurrent checks on the link between the two converter kernels
`timescale 1ns/10ps
module aks_link_properties
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Kernel end of the link
   input wire logic [1:0] dev_act,
   input wire logic dev_sync_req,
   input wire logic [aks_pkg::CHAN_W-1:0] dev_chan,
   input wire logic dev_ready,
   // Peer end of the link
   input wire logic [1:0] peer_act,
   input wire logic peer_sync_req,
   input wire logic [aks_pkg::CHAN_W-1:0] peer_chan,
   input wire logic peer_ready
);
   import aks_pkg::*;

   // ----------------------------------------
   // Clocking
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------
   // Link properties
   // ----------------------------------------
   master_ready_a : assert property (dev_sync_req |-> dev_ready)
      else $error("Kernel sync request without its own ready");
   peer_ready_a : assert property (peer_sync_req |-> peer_ready)
      else $error("Peer sync request without its own ready");
   joint_start_a : assert property (dev_ready && peer_ready |=> !dev_ready && !peer_ready)
      else $error("Kernels did not leave the wait together");
   hold_wait_a : assert property (dev_sync_req && !peer_ready |=> dev_sync_req)
      else $error("Master left the wait before the slave was ready");
   dev_leave_a : assert property ($fell(dev_ready) |-> $past(peer_ready))
      else $error("Kernel started without the peer being ready");
   peer_leave_a : assert property ($fell(peer_ready) |-> $past(dev_ready))
      else $error("Peer started without the kernel being ready");
   chan_hold_a : assert property (dev_sync_req ##1 dev_sync_req |-> $stable(dev_chan))
      else $error("Requested channel changed during the wait");
   chan_follow_a : assert property (dev_ready && !dev_sync_req && peer_sync_req |-> dev_chan == peer_chan)
      else $error("Slave channel differs from the master channel");
   req_active_a : assert property (dev_sync_req |-> dev_act != ACT_OFF)
      else $error("Sync request while the kernel is switched off");
endmodule : aks_link_properties

// *** sim/adc_kernel_sync_and_emux_enable_tb.sv ***
// Self-checking bench for the kernel and its peer joined by the link
`timescale 1ns/10ps
module adc_kernel_sync_and_emux_enable_tb;
   import aks_pkg::*;
   typedef struct packed {logic [15:0] idx; logic [15:0] wd; logic [1:0] be; logic [15:0] exp;} aks_row_t;
   localparam int KS = 2;
   localparam int KC = 3;
   localparam logic [7:0] KB = KERNEL0_BASE[15:8];
   logic ref_clk = 1'h0;
   logic rst_n = 1'h0;
   logic [ADDR_W-1:0] avs_address = 18'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [NUM_SRQ-1:0] service_request;
   logic ext_mux_active, converting, req_ack, conv_done, busy;
   logic [1:0] cfg_start_selection = 2'h1;
   logic cfg_peer_ready_evaluate = 1'h1;
   logic [1:0] cfg_activity_control_code = 2'h0;
   logic req_valid = 1'h0;
   logic req_sync = 1'h0;
   logic [CHAN_W-1:0] req_chan = 4'h0;
   logic clr = 1'h0;
   logic [7:0] seen = 8'h0;
   logic [15:0] rdata;
   int conv_len = 0;
   int cyc = 0;
   int fail_count = 0;
   int num_checks = 0;
   aks_row_t rows [10] = '{
      '{{KB, OFS_SYNC_CTRL}, 16'hff9f, 2'h3, 16'h0013},
      '{{KB, OFS_SYNC_CTRL}, 16'h0012, 2'h1, 16'h0012},
      '{{KB, OFS_SYNC_CTRL}, 16'hff10, 2'h2, 16'h0012},
      '{{KB, OFS_SYNC_CTRL}, 16'h0010, 2'h3, 16'h0010},
      '{{KB, OFS_EMUX_EN}, 16'hffff, 2'h2, 16'h5500},
      '{{KB, OFS_EMUX_EN}, 16'haaaa, 2'h3, 16'h0000},
      '{{KB, OFS_EMUX_EN}, 16'h0040, 2'h3, 16'h0040},
      '{{KB, 8'h10}, 16'hffff, 2'h3, 16'h0000},
      '{{KERNEL1_BASE[15:8], OFS_SYNC_CTRL}, 16'hff9f, 2'h3, 16'h0000},
      '{{KB, OFS_GLOBAL_CTRL}, 16'hffff, 2'h3, 16'h0003}};

   // ----------------------------------------
   // Design, link and checker
   // ----------------------------------------
   aks_link_if link();
   aks_kernel #(.BASE(KERNEL0_BASE), .SAMPLE_CYC(KS), .CONV_CYC(KC)) aks_kernel_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .service_request(service_request),
      .ext_mux_active(ext_mux_active), .converting(converting));
   aks_peer aks_peer_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .link(link), .cfg_start_selection(cfg_start_selection),
      .cfg_peer_ready_evaluate(cfg_peer_ready_evaluate),
      .cfg_activity_control_code(cfg_activity_control_code), .req_valid(req_valid),
      .req_sync(req_sync), .req_chan(req_chan), .req_ack(req_ack), .conv_done(conv_done),
      .busy(busy));
   aks_link_properties aks_link_properties_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .dev_act(link.dev_act), .dev_sync_req(link.dev_sync_req),
      .dev_chan(link.dev_chan), .dev_ready(link.dev_ready), .peer_act(link.peer_act),
      .peer_sync_req(link.peer_sync_req), .peer_chan(link.peer_chan),
      .peer_ready(link.peer_ready));

   // ----------------------------------------
   // Clock, event monitor and timeout
   // ----------------------------------------
   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      seen <= clr ? 8'h0 : seen | {req_ack, conv_done, ext_mux_active, converting, service_request};
      conv_len <= clr ? 0 : conv_len + int'(converting);
      if (cyc == 5000)
      begin
         fail_count++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("Checks made %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_flag(input logic got, input logic exp);
      chk_reg({15'h0, got}, {15'h0, exp});
   endtask : chk_flag

   task automatic bus(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                      input logic [1:0] be);
      int n;
      @(posedge ref_clk);
      avs_address <= {idx, 2'h0};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {16'h0, wd};
      avs_byteenable <= {2'h0, be};
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (avs_waitrequest !== 1'h0 && n < 20);
      rdata = avs_readdata[15:0];
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      if (avs_waitrequest !== 1'h0)
      begin
         fail_count++;
         end_sim();
      end
      if (!wr)
         chk_reg(avs_readdata[31:16], 16'h0000);
   endtask : bus

   task automatic wait_seen(input int b);
      int n;
      n = 0;
      while (seen[b] !== 1'h1 && n < 100)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk_flag(seen[b], 1'h1);
   endtask : wait_seen

   task automatic clear();
      @(posedge ref_clk);
      clr <= 1'h1;
      @(posedge ref_clk);
      clr <= 1'h0;
   endtask : clear

   task automatic peer_req(input logic sync, input logic [3:0] chan);
      @(posedge ref_clk);
      req_valid <= 1'h1;
      req_sync <= sync;
      req_chan <= chan;
      wait_seen(7);
      req_valid <= 1'h0;
   endtask : peer_req

   task automatic set_peer(input logic [1:0] sel, input logic ev, input logic [1:0] act);
      @(posedge ref_clk);
      cfg_start_selection <= sel;
      cfg_peer_ready_evaluate <= ev;
      cfg_activity_control_code <= act;
      @(posedge ref_clk);
   endtask : set_peer

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (8) @(posedge ref_clk);
      chk_flag(avs_waitrequest, 1'h1);
      chk_flag(busy, 1'h0);
      rst_n <= 1'h1;
      bus(1'h0, {KB, OFS_SYNC_CTRL}, 16'h0, 2'h3);
      chk_reg(rdata, REG_RESET);
      bus(1'h0, {KB, OFS_EMUX_EN}, 16'h0, 2'h3);
      chk_reg(rdata, REG_RESET);
      foreach (rows[i])
      begin
         bus(1'h1, rows[i].idx, rows[i].wd, rows[i].be);
         bus(1'h0, rows[i].idx, 16'h0, 2'h3);
         chk_reg(rdata, rows[i].exp);
      end
      // Parallel start held off until the slave is ready
      clear();
      peer_req(1'h0, 4'h1);
      chk_flag(busy, 1'h1);
      bus(1'h1, {KB, OFS_CONV_REQ}, 16'h0033, 2'h3);
      wait_seen(6);
      @(posedge ref_clk);
      chk_flag(seen[4], 1'h0);
      wait_seen(1);
      chk_reg(16'(conv_len), 16'(KS + KC));
      chk_flag(seen[5], 1'h1);
      chk_reg({12'h0, seen[3:0]}, 16'h0003);
      clear();
      bus(1'h1, {KB, OFS_CONV_REQ}, 16'h0022, 2'h3);
      wait_seen(0);
      chk_flag(seen[5], 1'h0);
      // Reserved start selection switches the kernel off
      bus(1'h1, {KB, OFS_GLOBAL_CTRL}, 16'h0000, 2'h3);
      clear();
      bus(1'h1, {KB, OFS_SYNC_CTRL}, 16'h0002, 2'h3);
      wait_seen(2);
      bus(1'h1, {KB, OFS_GLOBAL_CTRL}, 16'h0003, 2'h3);
      bus(1'h0, {KB, OFS_GLOBAL_STAT}, 16'h0, 2'h3);
      chk_reg({14'h0, rdata[1:0]}, {14'h0, ACT_OFF});
      // Kernel as slave of the peer
      bus(1'h1, {KB, OFS_GLOBAL_CTRL}, 16'h0000, 2'h3);
      set_peer(ROLE_MASTER, 1'h1, ACT_OFF);
      bus(1'h1, {KB, OFS_SYNC_CTRL}, 16'h0011, 2'h3);
      set_peer(ROLE_MASTER, 1'h1, ACT_ON);
      bus(1'h0, {KB, OFS_GLOBAL_STAT}, 16'h0, 2'h3);
      chk_reg({14'h0, rdata[1:0]}, {14'h0, ACT_ON});
      clear();
      peer_req(1'h1, 4'h2);
      wait_seen(1);
      // Evaluation off: kernel starts alone
      set_peer(ROLE_MASTER, 1'h0, ACT_OFF);
      bus(1'h1, {KB, OFS_SYNC_CTRL}, 16'h0000, 2'h3);
      bus(1'h1, {KB, OFS_GLOBAL_CTRL}, 16'h0003, 2'h3);
      clear();
      bus(1'h1, {KB, OFS_CONV_REQ}, 16'h0033, 2'h3);
      wait_seen(0);
      chk_reg({12'h0, seen[3:0]}, 16'h0001);
      end_sim();
   end
endmodule : adc_kernel_sync_and_emux_enable_tb
